// >>> pkg/ees_pkg.sv
package ees_pkg;
	localparam int         NBYTES     = 32;
	localparam logic [4:0] SENS_CFG   = 5'h00;
	localparam logic [4:0] READ_CFG   = 5'h01;
	localparam logic [4:0] FILT_CFG   = 5'h02;
	localparam logic [4:0] XLIM       = 5'h03;
	localparam logic [4:0] YLIM       = 5'h04;
	localparam logic [4:0] ZLIM       = 5'h05;
	localparam logic [4:0] ADDR_CFG   = 5'h06;
	localparam logic [4:0] USER_LAST  = 5'h08;
	localparam logic [4:0] USER_SUM   = 5'h09;
	localparam logic [4:0] FACT_FIRST = 5'h0A;
	localparam logic [4:0] FACT_LOCK  = 5'h1E;
	localparam logic [4:0] FACT_SUM   = 5'h1F;
	localparam int         LOCK_BIT   = 7;
	localparam logic [7:0] RA_STATUS  = 8'h00;
	localparam logic [7:0] RA_LONG    = 8'h01;
	localparam logic [7:0] RA_SHORT   = 8'h09;
	localparam logic [7:0] RA_SHORT_E = 8'h0C;
	localparam logic [7:0] RA_CMD     = 8'h0F;
	localparam logic [7:0] RA_SHADOW  = 8'h10;
	localparam logic [7:0] RA_SHAD_E  = 8'h2F;
	localparam logic [7:0] CMD_EXIT   = 8'h00;
	localparam logic [7:0] CMD_ENTER  = 8'hA5;
	localparam logic [7:0] CMD_PROG_U = 8'hC1;
	localparam logic [7:0] CMD_PROG_F = 8'hC2;
	localparam logic [7:0] CMD_LOAD   = 8'hD0;
	localparam logic [7:0] DEF_BYTE   = 8'h00;
	localparam logic [3:0] BIT_LAST   = 4'h7;
	localparam logic [3:0] ACK_SLOT   = 4'h8;
	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_LOAD = 2'b01,
		E_PROG = 2'b10
	} ees_eng_t;
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_PTR  = 3'b010,
		I_WR   = 3'b011,
		I_RD   = 3'b100
	} ees_i2c_t;
	typedef struct packed {
		logic [3:0][15:0] ch;
	} ees_res_t;
	typedef struct packed {
		logic [3:0] vld;
		logic       acq_start;
		logic       cont;
	} ees_evt_t;
	typedef struct packed {
		logic [7:0]  sensor;
		logic [7:0]  readout;
		logic [7:0]  filter;
		logic [7:0]  routing;
		logic [15:0] xthr;
		logic [15:0] ythr;
		logic [15:0] zthr;
		logic [6:0]  slave_addr;
	} ees_cfg_t;
endpackage

// >>> src/ees_top.sv
module ees_top #(
	// arbitrary upper slave address bits
	parameter logic [2:0] ADDR_HI = 3'h3
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          scl,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	input  wire ees_pkg::ees_res_t res_in,
	input  wire ees_pkg::ees_evt_t evt_in,
	output ees_pkg::ees_cfg_t  cfg_out
);
	// ==========================================
	// resets
	logic [1:0] rsync_reg;
	logic [1:0] ssync_reg;
	wire        rst_n  = rsync_reg[1];
	wire        srst_n = ssync_reg[1];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rsync_reg <= 2'h0;
		else rsync_reg <= {rsync_reg[0], 1'b1};
	end

	// release in the scl domain needs scl edges; a frame supplies them
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) ssync_reg <= 2'h0;
		else ssync_reg <= {ssync_reg[0], 1'b1};
	end

	function automatic logic is_fact(input logic [4:0] a);
		return a >= ees_pkg::FACT_FIRST;
	endfunction

	// ==========================================
	// store and checksums
	// starts blank so both page sums fail until a page is programmed
	logic [7:0] mem [ees_pkg::NBYTES] = '{default: 8'h00};
	logic [7:0] shadow_reg [ees_pkg::NBYTES];
	logic [7:0] usum;
	logic [7:0] fsum;

	always_comb begin
		usum = 8'h00;
		fsum = 8'h00;
		for (int i = 0; i < ees_pkg::NBYTES; i++) begin
			if (i <= int'(ees_pkg::USER_LAST)) usum = usum + mem[i];
			else if (i >= int'(ees_pkg::FACT_FIRST) && i < int'(ees_pkg::FACT_SUM))
				fsum = fsum + mem[i];
		end
	end

	wire usum_ok = (usum - 8'h01) == mem[ees_pkg::USER_SUM];
	wire fsum_ok = (fsum - 8'h01) == mem[ees_pkg::FACT_SUM];
	wire lock_u  = mem[ees_pkg::USER_LAST][ees_pkg::LOCK_BIT];
	// byte 30 bit 7 guards the factory page it lives in
	wire lock_f  = mem[ees_pkg::FACT_LOCK][ees_pkg::LOCK_BIT];

	// ==========================================
	// write crossing from scl
	logic       wr_tgl_reg;
	logic [7:0] wa_reg;
	logic [7:0] wd_reg;
	logic [2:0] wt_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) wt_reg <= 3'h0;
		else wt_reg <= {wt_reg[1:0], wr_tgl_reg};
	end
	wire        wr_evt  = wt_reg[2] ^ wt_reg[1];
	wire        in_shad = wa_reg >= ees_pkg::RA_SHADOW
		&& wa_reg <= ees_pkg::RA_SHAD_E;
	wire [4:0]  widx    = 5'(wa_reg - ees_pkg::RA_SHADOW);
	wire        cmd_go  = wr_evt && wa_reg == ees_pkg::RA_CMD;

	// ==========================================
	// engine
	ees_pkg::ees_eng_t eng_reg;
	logic [4:0] idx_reg;
	logic [4:0] last_reg;
	logic       boot_reg;
	logic       access_reg;
	logic       fsum_ok_reg;
	wire        idle   = eng_reg == ees_pkg::E_IDLE;
	wire        go_u   = cmd_go && idle && wd_reg == ees_pkg::CMD_PROG_U;
	wire        go_f   = cmd_go && idle && wd_reg == ees_pkg::CMD_PROG_F;
	wire        go_ld  = cmd_go && idle && wd_reg == ees_pkg::CMD_LOAD;
	wire        ok_u   = go_u && access_reg && !lock_u;
	wire        ok_f   = go_f && access_reg && !lock_f;
	wire        pg_ok  = is_fact(idx_reg) ? fsum_ok : usum_ok;
	wire        idx_end = idx_reg == last_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eng_reg     <= ees_pkg::E_LOAD;
			idx_reg     <= 5'h00;
			last_reg    <= ees_pkg::FACT_SUM;
			boot_reg    <= 1'b1;
			access_reg  <= 1'b0;
			fsum_ok_reg <= 1'b0;
		end else begin
			fsum_ok_reg <= fsum_ok;
			unique case (eng_reg)
			ees_pkg::E_IDLE: begin
				if (cmd_go && wd_reg == ees_pkg::CMD_ENTER) access_reg <= 1'b1;
				if (cmd_go && wd_reg == ees_pkg::CMD_EXIT) access_reg <= 1'b0;
				if (ok_u || ok_f) begin
					eng_reg  <= ees_pkg::E_PROG;
					idx_reg  <= ok_f ? ees_pkg::FACT_FIRST : 5'h00;
					last_reg <= ok_f ? ees_pkg::FACT_SUM : ees_pkg::USER_SUM;
				end else if (go_ld) begin
					eng_reg  <= ees_pkg::E_LOAD;
					idx_reg  <= 5'h00;
					last_reg <= ees_pkg::FACT_SUM;
				end
			end
			default: begin
				idx_reg <= idx_reg + 5'h01;
				if (idx_end) begin
					eng_reg  <= ees_pkg::E_IDLE;
					boot_reg <= 1'b0;
				end
			end
			endcase
		end
	end

	// no reset: the array is the non-volatile content
	always_ff @(posedge clk) begin
		if (eng_reg == ees_pkg::E_PROG) mem[idx_reg] <= shadow_reg[idx_reg];
	end

	// ==========================================
	// shadows
	wire fact_block = is_fact(widx) && lock_f;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ees_pkg::NBYTES; i++) shadow_reg[i] <= ees_pkg::DEF_BYTE;
		end else if (eng_reg == ees_pkg::E_LOAD) begin
			// boot falls back to defaults on a bad page sum
			shadow_reg[idx_reg] <= (boot_reg && !pg_ok) ? ees_pkg::DEF_BYTE
				: mem[idx_reg];
		end else if (wr_evt && in_shad && idle && !fact_block) begin
			shadow_reg[widx] <= wd_reg;
		end
	end

	// ==========================================
	// configuration to the sensor core
	ees_pkg::ees_cfg_t cfg_reg;
	wire [7:0] adr_b = shadow_reg[ees_pkg::ADDR_CFG];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cfg_reg <= '0;
		else begin
			cfg_reg.sensor     <= shadow_reg[ees_pkg::SENS_CFG];
			cfg_reg.readout    <= shadow_reg[ees_pkg::READ_CFG];
			cfg_reg.filter     <= shadow_reg[ees_pkg::FILT_CFG];
			cfg_reg.routing    <= adr_b;
			cfg_reg.xthr       <= {shadow_reg[ees_pkg::XLIM], 8'h00};
			cfg_reg.ythr       <= {shadow_reg[ees_pkg::YLIM], 8'h00};
			cfg_reg.zthr       <= {shadow_reg[ees_pkg::ZLIM], 8'h00};
			cfg_reg.slave_addr <= {ADDR_HI, adr_b[4:3], adr_b[1:0]};
		end
	end
	assign cfg_out = cfg_reg;

	// ==========================================
	// results and valid flags
	logic [3:0]  vld_w;
	logic [15:0] res_w [4];
	for (genvar c = 0; c < 4; c++) begin : g_ch
		logic        vld_reg;
		logic [15:0] res_reg;
		// set beats a clear arriving in the same cycle
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				vld_reg <= 1'b0;
				res_reg <= 16'h0000;
			end else if (evt_in.vld[c]) begin
				vld_reg <= 1'b1;
				res_reg <= res_in.ch[c];
			end else if (evt_in.acq_start && !evt_in.cont) begin
				vld_reg <= 1'b0;
			end
		end
		assign vld_w[c] = vld_reg;
		assign res_w[c] = res_reg;
	end

	// ==========================================
	// status crossing to scl
	logic [6:0] stat_src_reg;
	logic [6:0] stat_s1_reg;
	logic [6:0] stat_s2_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) stat_src_reg <= 7'h00;
		else stat_src_reg <= {wt_reg[2], !idle, vld_w, fsum_ok_reg};
	end
	always_ff @(posedge scl or negedge srst_n) begin
		if (!srst_n) begin
			stat_s1_reg <= 7'h00;
			stat_s2_reg <= 7'h00;
		end else begin
			stat_s1_reg <= stat_src_reg;
			stat_s2_reg <= stat_s1_reg;
		end
	end
	// pending write counts as busy until the clock side took it
	wire       pend   = wr_tgl_reg ^ stat_s2_reg[6];
	wire [7:0] status = {2'b00, stat_s2_reg[5] | pend,
		stat_s2_reg[4:0]};

	// ==========================================
	// slave on scl
	ees_pkg::ees_i2c_t ist_reg;
	logic       sda_hi_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] ptr_reg;
	logic [7:0] tx_reg;
	logic       rd_reg;
	logic       oe_reg;

	always_ff @(posedge scl or negedge srst_n) begin
		if (!srst_n) sda_hi_reg <= 1'b1;
		else sda_hi_reg <= sda_in;
	end

	// result words are held by their valid flags, read without resync
	wire [7:0] lidx    = 8'(ptr_reg - ees_pkg::RA_LONG);
	wire [7:0] sidx    = 8'(ptr_reg - ees_pkg::RA_SHORT);
	wire [7:0] didx    = 8'(ptr_reg - ees_pkg::RA_SHADOW);
	wire [15:0] lword  = res_w[lidx[2:1]];
	wire        p_long = ptr_reg >= ees_pkg::RA_LONG && ptr_reg < ees_pkg::RA_SHORT;
	wire        p_shrt = ptr_reg >= ees_pkg::RA_SHORT && ptr_reg <= ees_pkg::RA_SHORT_E;
	wire        p_shad = ptr_reg >= ees_pkg::RA_SHADOW && ptr_reg <= ees_pkg::RA_SHAD_E;
	wire [7:0]  rd_byte =
		(ptr_reg == ees_pkg::RA_STATUS) ? status :
		p_long ? (lidx[0] ? lword[7:0] : lword[15:8]) :
		p_shrt ? res_w[sidx[1:0]][15:8] :
		p_shad ? shadow_reg[didx[4:0]] : 8'h00;

	wire [7:0] byte_in   = {sh_reg[6:0], sda_hi_reg};
	wire       start_det = sda_hi_reg && !sda_in;
	wire       byte_done = cnt_reg == ees_pkg::BIT_LAST;
	wire       ack_end   = cnt_reg == ees_pkg::ACK_SLOT;
	wire       adr_hit   = byte_in[7:1] == cfg_reg.slave_addr;

	always_ff @(negedge scl or negedge srst_n) begin
		if (!srst_n) begin
			ist_reg    <= ees_pkg::I_IDLE;
			cnt_reg    <= 4'h0;
			sh_reg     <= 8'h00;
			ptr_reg    <= 8'h00;
			tx_reg     <= 8'h00;
			rd_reg     <= 1'b0;
			oe_reg     <= 1'b0;
			wr_tgl_reg <= 1'b0;
			wa_reg     <= 8'h00;
			wd_reg     <= 8'h00;
		end else if (start_det) begin
			ist_reg <= ees_pkg::I_ADDR;
			cnt_reg <= 4'h0;
			oe_reg  <= 1'b0;
		end else if (ist_reg != ees_pkg::I_IDLE) begin
			sh_reg  <= byte_in;
			cnt_reg <= ack_end ? 4'h0 : cnt_reg + 4'h1;
			if (byte_done) begin
				oe_reg <= ist_reg != ees_pkg::I_RD;
				unique case (ist_reg)
				ees_pkg::I_ADDR: begin
					rd_reg <= byte_in[0];
					if (!adr_hit) begin
						ist_reg <= ees_pkg::I_IDLE;
						oe_reg  <= 1'b0;
					end
				end
				ees_pkg::I_PTR: ptr_reg <= byte_in;
				ees_pkg::I_WR: begin
					wa_reg     <= ptr_reg;
					wd_reg     <= byte_in;
					wr_tgl_reg <= !wr_tgl_reg;
					ptr_reg    <= ptr_reg + 8'h01;
				end
				default: ;
				endcase
			end else if (ack_end) begin
				oe_reg <= 1'b0;
				if (ist_reg == ees_pkg::I_ADDR)
					ist_reg <= rd_reg ? ees_pkg::I_RD : ees_pkg::I_PTR;
				else if (ist_reg == ees_pkg::I_PTR)
					ist_reg <= ees_pkg::I_WR;
				if ((ist_reg == ees_pkg::I_ADDR && rd_reg)
					|| (ist_reg == ees_pkg::I_RD && !sda_hi_reg)) begin
					tx_reg  <= rd_byte;
					oe_reg  <= !rd_byte[7];
					ptr_reg <= ptr_reg + 8'h01;
				end else if (ist_reg == ees_pkg::I_RD) begin
					ist_reg <= ees_pkg::I_IDLE;
				end
			end else if (ist_reg == ees_pkg::I_RD) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
				oe_reg <= !tx_reg[6];
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(negedge scl or negedge srst_n) begin
		if (!srst_n) sda_out <= 1'b0;
		else sda_out <= 1'b0;
	end
	assign sda_oe = oe_reg;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_prog_u;
		ok_u;
	endsequence
	sequence s_prog_body;
		(eng_reg == ees_pkg::E_PROG)[*8] ##2 eng_reg == ees_pkg::E_PROG
			##1 eng_reg == ees_pkg::E_IDLE;
	endsequence

	property p_prog_user;
		s_prog_u |=> s_prog_body;
	endproperty
	a_prog_user: assert property (p_prog_user) else $error("user program length");

	property p_prog_access;
		eng_reg == ees_pkg::E_PROG |-> access_reg;
	endproperty
	a_prog_access: assert property (p_prog_access) else $error("program without access");

	property p_lock_refuse;
		go_f && lock_f |=> eng_reg == ees_pkg::E_IDLE;
	endproperty
	a_lock_refuse: assert property (p_lock_refuse) else $error("locked page programmed");

	property p_fact_frozen;
		wr_evt && in_shad && fact_block |=> shadow_reg[$past(widx)] == $past(shadow_reg[widx]);
	endproperty
	a_fact_frozen: assert property (p_fact_frozen) else $error("locked shadow changed");

	property p_load_len;
		go_ld |=> eng_reg == ees_pkg::E_LOAD ##31 eng_reg == ees_pkg::E_LOAD ##1 idle;
	endproperty
	a_load_len: assert property (p_load_len) else $error("load length");

	property p_boot_default;
		boot_reg && eng_reg == ees_pkg::E_LOAD && !is_fact(idx_reg) && !usum_ok
			|=> shadow_reg[$past(idx_reg)] == ees_pkg::DEF_BYTE;
	endproperty
	a_boot_default: assert property (p_boot_default) else $error("bad page loaded");

	property p_vld_set;
		evt_in.vld[0] |=> vld_w[0] && res_w[0] == $past(res_in.ch[0]);
	endproperty
	a_vld_set: assert property (p_vld_set) else $error("result not captured");

	property p_vld_clear;
		evt_in.acq_start && !evt_in.cont && !evt_in.vld[1] |=> !vld_w[1];
	endproperty
	a_vld_clear: assert property (p_vld_clear) else $error("flag not cleared");

	property p_cont_hold;
		evt_in.cont && vld_w[2] |=> vld_w[2];
	endproperty
	a_cont_hold: assert property (p_cont_hold) else $error("continuous flag dropped");

	property p_thr_scale;
		1'b1 |=> cfg_reg.xthr == {$past(shadow_reg[ees_pkg::XLIM]), 8'h00};
	endproperty
	a_thr_scale: assert property (p_thr_scale) else $error("limit scale");

	property p_busy_seen;
		!idle |=> stat_src_reg[5];
	endproperty
	a_busy_seen: assert property (p_busy_seen) else $error("busy not reported");
endmodule // ees_top

// >>> verif/ees_host.sv
// ========================================
// i2c host model, open drain, pull-up on sda
module ees_host (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// scl stands still between frames, 6 ns bit period
	task automatic bit_io(input logic b, output logic r);
		#1 sda_pull = ~b;
		#2 scl = 1'b1;
		r = sda;
		#3 scl = 1'b0;
	endtask
	// low phase first so the rise samples a released line
	task automatic start();
		#1 scl = 1'b0;
		#1 sda_pull = 1'b0;
		#2 scl = 1'b1;
		#2 sda_pull = 1'b1;
		#1 scl = 1'b0;
	endtask
	task automatic stop();
		#1 sda_pull = 1'b1;
		#2 scl = 1'b1;
		#2 sda_pull = 1'b0;
	endtask
	task automatic xfer(
		input  logic [7:0] d,
		input  logic       nak,
		output logic [7:0] q,
		output logic       ack
	);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nak, r);
		ack = ~r;
	endtask
endmodule // ees_host

// >>> verif/eeprom_shadow_and_readout_regs_test.sv
module eeprom_shadow_and_readout_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [2:0] HI = 3'h5;
	logic              clk = 1'b0;
	logic              resetn;
	logic              scl;
	logic              sda_pull;
	wire logic         sda_in;
	logic              sda_out;
	logic              sda_oe;
	ees_pkg::ees_res_t res_in;
	ees_pkg::ees_res_t res;
	ees_pkg::ees_evt_t evt_in;
	ees_pkg::ees_cfg_t cfg_out;
	logic [7:0]        img [32];
	logic [7:0]        rb [13];
	logic [6:0]        dev;
	logic [7:0]        q;
	logic              k;
	int                seed = 86;
	int                n_mismatch = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	// ========================================
	// wiring
	assign sda_in = ~(sda_pull | (sda_oe & ~sda_out));
	ees_top #(.ADDR_HI(HI)) u_dut (
		.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .res_in(res_in),
		.evt_in(evt_in), .cfg_out(cfg_out)
	);
	ees_host u_host (.scl(scl), .sda_pull(sda_pull), .sda(sda_in));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	// ========================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [7:0] csum(input int lo, input int hi);
		logic [7:0] s;
		s = 8'hFF;
		for (int i = lo; i <= hi; i++)
			s = s + img[i];
		return s;
	endfunction
	// single-byte writes only: bursts need 400 ns between bytes
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
		#($unsigned($random(seed)) % 97);
		u_host.start();
		u_host.xfer({dev, 1'b0}, 1'b1, q, k);
		u_host.xfer(p, 1'b1, q, k);
		u_host.xfer(d, 1'b1, q, k);
		u_host.stop();
		chk(k, 1'b1);
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		#($unsigned($random(seed)) % 97);
		u_host.start();
		u_host.xfer({dev, 1'b0}, 1'b1, q, k);
		u_host.xfer(p, 1'b1, q, k);
		u_host.start();
		u_host.xfer({dev, 1'b1}, 1'b1, q, k);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(8'hFF, i == n - 1, q, k);
			rb[i] = q;
		end
		u_host.stop();
	endtask
	// 8 idle cycles: pending write is done, long engine runs still busy
	task automatic cmd(input logic [7:0] c, input int e);
		int t;
		wr(ees_pkg::RA_CMD, c, 8);
		rd(ees_pkg::RA_STATUS, 1);
		if (e >= 0)
			chk(rb[0][5], e[0]);
		for (t = 0; t < 40 && rb[0][5] !== 1'b0; t++)
			rd(ees_pkg::RA_STATUS, 1);
		chk(rb[0][5], 1'b0);
	endtask
	task automatic wimg(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			wr(ees_pkg::RA_SHADOW + i[7:0], img[i], 6);
			if (i == 6)
				dev = {HI, img[6][4:3], img[6][1:0]};
		end
	endtask
	task automatic check_res(input logic [7:0] st);
		rd(ees_pkg::RA_STATUS, 13);
		chk(rb[0], st);
		for (int i = 0; i < 4; i++) begin
			chk(rb[1 + 2 * i], res.ch[i][15:8]);
			chk(rb[2 + 2 * i], res.ch[i][7:0]);
			chk(rb[9 + i], res.ch[i][15:8]);
		end
	endtask
	task automatic pulse(input logic [5:0] e);
		@(negedge clk);
		evt_in = ees_pkg::ees_evt_t'(e);
		@(negedge clk);
		evt_in = ees_pkg::ees_evt_t'({5'h00, e[0]});
	endtask
	task automatic new_res();
		@(negedge clk);
		res_in = ees_pkg::ees_res_t'({$random(seed), $random(seed)});
	endtask
	// scl toggles in and after reset so its domain releases too
	task automatic do_reset();
		@(negedge clk);
		resetn = 1'b0;
		repeat (4) u_host.bit_io(1'b1, k);
		repeat (16) @(negedge clk);
		chk(sda_oe, 1'b0);
		chk(cfg_out.sensor, 8'h00);
		resetn = 1'b1;
		repeat (4) u_host.bit_io(1'b1, k);
		u_host.stop();
		repeat (45) @(negedge clk);
	endtask
	// ========================================
	// main sequence
	initial begin
		resetn = 1'b0;
		res_in = '0;
		evt_in = '0;
		dev = {HI, 4'h0};
		do_reset();
		chk(cfg_out.sensor, ees_pkg::DEF_BYTE);
		chk(cfg_out.slave_addr, dev);
		#20;
		u_host.start();
		u_host.xfer({dev ^ 7'h01, 1'b0}, 1'b1, q, k);
		u_host.stop();
		chk(k, 1'b0);
		new_res();
		res = res_in;
		pulse(6'h3C);
		check_res(8'h1E);
		wr(8'h01, 8'h5A, 6);
		new_res();
		pulse(6'h03);
		check_res(8'h1E);
		pulse(6'h02);
		check_res(8'h00);
		for (int i = 0; i < 32; i++)
			img[i] = $random(seed);
		img[8][7] = 1'b0;
		img[30][7] = 1'b0;
		img[9] = csum(0, 8);
		img[31] = csum(10, 30);
		wimg(0, 31);
		chk(cfg_out.sensor, img[0]);
		chk(cfg_out.readout, img[1]);
		chk(cfg_out.filter, img[2]);
		chk(cfg_out.routing, img[6]);
		chk(cfg_out.xthr, {img[3], 8'h00});
		chk(cfg_out.ythr, {img[4], 8'h00});
		chk(cfg_out.zthr, {img[5], 8'h00});
		chk(cfg_out.slave_addr, dev);
		cmd(ees_pkg::CMD_ENTER, 0);
		cmd(ees_pkg::CMD_PROG_U, -1);
		cmd(ees_pkg::CMD_PROG_F, 1);
		cmd(ees_pkg::CMD_EXIT, 0);
		wr(ees_pkg::RA_SHADOW, ~img[0], 6);
		cmd(ees_pkg::CMD_PROG_U, 0);
		cmd(ees_pkg::CMD_LOAD, 1);
		chk(cfg_out.sensor, img[0]);
		cmd(ees_pkg::CMD_ENTER, 0);
		img[8][7] = 1'b1;
		img[9] = csum(0, 8);
		wimg(8, 9);
		cmd(ees_pkg::CMD_PROG_U, -1);
		wr(ees_pkg::RA_SHADOW, ~img[0], 6);
		cmd(ees_pkg::CMD_PROG_U, 0);
		img[30][7] = 1'b1;
		img[31] = csum(10, 30);
		wimg(30, 31);
		cmd(ees_pkg::CMD_PROG_F, 1);
		wr(8'h1A, ~img[10], 6);
		rd(8'h1A, 1);
		chk(rb[0], img[10]);
		cmd(ees_pkg::CMD_PROG_F, 0);
		// second reset: stored pages now carry good checksums
		do_reset();
		chk(cfg_out.sensor, img[0]);
		rd(ees_pkg::RA_STATUS, 1);
		chk(rb[0], 8'h01);
		rd(8'h1A, 1);
		chk(rb[0], img[10]);
		final_report();
	end
endmodule // eeprom_shadow_and_readout_regs_test
